// ### hw/lhp_port.sv
// ============================================================
// Purpose: host bus port of a two-half graphic lcd module
// Assumes: all host pins asynchronous to clk; display logic on clk
// Notes:   bus style follows the resting level of the reset pin
//
// Overview of operation
// - register select high means display data, low means instruction or status.
// - two active-low selects each enable one half; a high select ignores it.
// - enable style drives read data while enable is high, writes on its fall.
// - separate style drives read data while the read strobe is low.
// - separate style captures the data bus on the write strobe's rising edge.
// - the resting level of the reset pin selects the bus style.
// - enable style resets on a rising reset pin edge, pin then held high.
// - separate style resets on a falling reset pin edge, pin then held low.
// - data reads pass a holding latch; one dummy read is needed first.
// - busy flag shows on data bit 7 of a status read.
// - a deselected half stays in standby and ignores the bus.
`default_nettype none
// ============================================================
// three-stage synchroniser with agreement filter
module lhp_pin_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // pins and filtered levels
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] differ;
  // a bit moves only once stages two and three agree
  assign differ = s2_reg ^ s3_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_reg    <= INIT;
      s2_reg    <= INIT;
      s3_reg    <= INIT;
      level_out <= INIT;
    end else begin
      s1_reg    <= pin_in;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_out <= (s3_reg & ~differ) | (level_out & differ);
    end
  end
endmodule

// ============================================================
// host bus port top
module lhp_port import lhp_pkg::*; (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // host pins
  input  wire logic                  data_or_command_select,
  input  wire logic                  half_one_select_n,
  input  wire logic                  half_two_select_n,
  input  wire logic                  scan_tick_input,
  input  wire logic                  strobe_pin,
  input  wire logic                  direction_pin,
  input  wire logic                  mode_reset_pin,
  input  wire logic [DATA_W-1:0]     host_data_bus_in,
  output logic      [DATA_W-1:0]     host_data_bus_out,
  output logic                       host_data_bus_oe_n,
  // write words towards the display logic
  output logic                       wr_valid,
  output lhp_wr_word_s               wr_word,
  input  wire logic                  wr_ready,
  // display ram fetch into the holding latch
  output logic                       fetch_req,
  output logic                       fetch_half,
  input  wire logic                  fetch_valid,
  input  wire logic [DATA_W-1:0]     fetch_data,
  // status from the display logic
  input  wire logic [HALVES-1:0]     busy_flag,
  input  wire logic [HALVES-1:0][STATUS_W-1:0] status_bits,
  // control towards the display logic
  output logic                       port_reset_pulse,
  output logic                       bus_mode_enable,
  output logic                       scan_tick
);
  // ============================================================
  // pin synchronisation
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_f;
  logic [PIN_W-1:0] pins_prev_reg;
  assign pins_raw = {mode_reset_pin, data_or_command_select, half_one_select_n,
                     half_two_select_n, scan_tick_input, strobe_pin, direction_pin,
                     host_data_bus_in};
  lhp_pin_sync #(.WIDTH(PIN_W), .INIT(PIN_IDLE)) u_sync (
    .clk       (clk),
    .reset     (reset),
    .pin_in    (pins_raw),
    .level_out (pins_f)
  );
  // filtered pins one cycle back, for edge detection
  always_ff @(posedge clk) begin
    if (reset) pins_prev_reg <= PIN_IDLE;
    else pins_prev_reg <= pins_f;
  end

  // ============================================================
  // decode of filtered pins
  logic              rst_f;
  logic              a0_f;
  logic              strobe_f;
  logic              dir_f;
  logic [HALVES-1:0] sel;
  logic              any_sel;
  logic [DATA_W-1:0] bus_f;
  logic              mode_reg;
  logic              port_rst_reg;
  assign rst_f    = pins_f[PIN_RST];
  assign a0_f     = pins_f[PIN_A0];
  assign strobe_f = pins_f[PIN_STROBE];
  assign dir_f    = pins_f[PIN_DIR];
  assign bus_f    = pins_f[PIN_BUS_LSB +: DATA_W];
  // each select enables its own half
  assign sel      = ~{pins_f[PIN_SEL2_N], pins_f[PIN_SEL1_N]};
  assign any_sel  = |sel;

  // ============================================================
  // bus style and port reset from the reset pin
  logic rst_edge;
  assign rst_edge = rst_f ^ pins_prev_reg[PIN_RST];
  // rising edge resets into enable style
  // falling edge resets into separate style
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_reg     <= MODE_RESET;
      port_rst_reg <= 1'h0;
    end else begin
      mode_reg     <= rst_f;
      port_rst_reg <= rst_edge;
    end
  end
  assign port_reset_pulse = port_rst_reg;
  assign bus_mode_enable  = mode_reg;
  // scan clock edge handed on as one pulse
  assign scan_tick = pins_f[PIN_SCAN] & ~pins_prev_reg[PIN_SCAN];

  // ============================================================
  // access detection
  logic read_now;
  logic wr_fall_en;
  logic wr_rise_sep;
  logic wr_take;
  logic read_half;
  // direction high requests a read in enable style
  // read window is read strobe low
  assign read_now    = any_sel & (mode_reg ? (strobe_f & dir_f) : (~strobe_f & dir_f));
  // write on falling enable with direction low
  assign wr_fall_en  = pins_prev_reg[PIN_STROBE] & ~strobe_f & ~dir_f;
  // write on rising write strobe, read strobe idle
  assign wr_rise_sep = ~pins_prev_reg[PIN_DIR] & dir_f & strobe_f;
  // deselected halves never take a write
  assign wr_take     = any_sel & (mode_reg ? wr_fall_en : wr_rise_sep);
  assign read_half   = ~sel[0];  // half one wins if both selected

  // ============================================================
  // two-entry write buffer
  lhp_wr_word_s buf_mem [BUF_DEPTH];
  logic         buf_wptr_reg;
  logic         buf_rptr_reg;
  logic [1:0]   buf_count_reg;
  logic         buf_full;
  logic         push;
  logic         pop;
  assign buf_full = (buf_count_reg == 2'(BUF_DEPTH));
  assign push     = wr_take & ~buf_full & ~port_rst_reg;
  assign pop      = wr_valid & wr_ready & ~port_rst_reg;
  assign wr_valid = (buf_count_reg != 2'h0);
  assign wr_word  = buf_mem[buf_rptr_reg];
  always_ff @(posedge clk) begin
    if (push) buf_mem[buf_wptr_reg] <= '{half_mask: sel, is_data: a0_f, value: bus_f};
  end
  always_ff @(posedge clk) begin
    if (reset || port_rst_reg) begin
      buf_wptr_reg  <= 1'h0;
      buf_rptr_reg  <= 1'h0;
      buf_count_reg <= 2'h0;
    end else begin
      buf_wptr_reg  <= buf_wptr_reg ^ push;
      buf_rptr_reg  <= buf_rptr_reg ^ pop;
      buf_count_reg <= buf_count_reg + 2'(push) - 2'(pop);
    end
  end

  // ============================================================
  // holding latch and read path
  logic [DATA_W-1:0] holder_reg [HALVES];
  logic              rd_active_reg;
  logic              rd_data_reg;
  logic              rd_half_reg;
  logic              fetch_req_reg;
  logic              fetch_half_reg;
  logic              busy_seen;
  logic [DATA_W-1:0] status_byte;
  logic [DATA_W-1:0] read_value;
  logic [DATA_W-1:0] out_reg;
  logic              oe_n_reg;
  logic              rd_end;
  // busy on bit 7; a full buffer also reads busy
  assign busy_seen   = busy_flag[read_half] | buf_full;
  assign status_byte = {busy_seen, status_bits[read_half]};
  // data reads come from the latch, others from status
  assign read_value  = a0_f ? holder_reg[read_half] : status_byte;
  assign rd_end      = rd_active_reg & ~read_now;
  always_ff @(posedge clk) begin
    if (reset) begin
      out_reg  <= DATA_RESET;
      oe_n_reg <= 1'h1;
    end else begin
      if (read_now) out_reg <= read_value;
      // drive only inside a selected read
      oe_n_reg <= ~read_now;
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_active_reg <= 1'h0;
      rd_data_reg   <= 1'h0;
      rd_half_reg   <= 1'h0;
    end else begin
      rd_active_reg <= read_now;
      if (read_now) rd_data_reg <= a0_f;
      if (read_now) rd_half_reg <= read_half;
    end
  end
  // a finished data read refills the latch for the next read
  always_ff @(posedge clk) begin
    if (reset || port_rst_reg) begin
      fetch_req_reg  <= 1'h0;
      fetch_half_reg <= 1'h0;
    end else begin
      fetch_req_reg <= rd_end & rd_data_reg;
      if (rd_end & rd_data_reg) fetch_half_reg <= rd_half_reg;
    end
  end
  always_ff @(posedge clk) begin
    if (reset || port_rst_reg) begin
      holder_reg[0] <= DATA_RESET;
      holder_reg[1] <= DATA_RESET;
    end else if (fetch_valid) begin
      holder_reg[fetch_half_reg] <= fetch_data;
    end
  end
  assign host_data_bus_out  = out_reg;
  assign host_data_bus_oe_n = oe_n_reg;
  assign fetch_req          = fetch_req_reg;
  assign fetch_half         = fetch_half_reg;

  // ============================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_read_drives_bus: assert property (read_now ##1 read_now |-> !host_data_bus_oe_n)
    else $error("bus not driven during read");
  a_bus_floats_idle: assert property (!read_now |=> host_data_bus_oe_n)
    else $error("bus driven outside a read");
  a_standby_ignores: assert property ((!any_sel && !pop && !port_rst_reg) |=>
      $stable(buf_count_reg))
    else $error("deselected port took a write");
  a_enable_capture: assert property ((mode_reg && wr_fall_en && any_sel && !buf_full
      && !port_rst_reg) |=> wr_valid)
    else $error("enable style write lost");
  a_strobe_capture: assert property ((!mode_reg && $rose(dir_f) && strobe_f && any_sel
      && !buf_full && !port_rst_reg) |=> wr_valid)
    else $error("separate style write lost");
  a_word_class: assert property ((push && buf_count_reg == 2'h0) |=>
      wr_word.is_data == $past(a0_f) && wr_word.half_mask == $past(sel))
    else $error("write word class or half wrong");
  a_status_busy: assert property ((read_now && !a0_f && busy_flag[read_half]) |=>
      host_data_bus_out[BUSY_BIT])
    else $error("busy flag missing on status read");
  a_style_follow: assert property ($changed(rst_f) |=> port_reset_pulse
      && bus_mode_enable == $past(rst_f))
    else $error("reset pin edge not followed");
  a_latch_refill: assert property ((rd_end && rd_data_reg && !port_rst_reg) |=>
      fetch_req ##1 !fetch_req)
    else $error("data read did not refill latch");
  c_enable_write: cover property (mode_reg && wr_take ##1 wr_valid);
  c_strobe_read: cover property (!mode_reg && read_now ##1 read_now ##1 rd_end);
  c_buffer_full: cover property (buf_full && wr_take);
  c_port_reset: cover property (port_reset_pulse && mode_reg);
endmodule

`default_nettype wire

// ### hw/lhp_pkg.sv
// ============================================================
// Purpose: shared constants and types for the lcd host bus port
// Assumes: 8-bit host bus, two controller halves, one 50 MHz clock
// Notes:   pin vector order is fixed here and used by the port
`default_nettype none

package lhp_pkg;

  // ============================================================
  // widths and counts
  localparam int DATA_W      = 8;
  localparam int HALVES      = 2;
  localparam int STATUS_W    = 7;
  localparam int BUSY_BIT    = 7;
  localparam int BUF_DEPTH   = 2;
  localparam int SYNC_STAGES = 3;
  localparam int PIN_W       = 15;

  // ============================================================
  // pin vector field positions
  localparam int PIN_BUS_LSB = 0;
  localparam int PIN_DIR     = 8;   // direction in enable style, write strobe otherwise
  localparam int PIN_STROBE  = 9;   // enable in enable style, read strobe otherwise
  localparam int PIN_SCAN    = 10;
  localparam int PIN_SEL2_N  = 11;
  localparam int PIN_SEL1_N  = 12;
  localparam int PIN_A0      = 13;
  localparam int PIN_RST     = 14;

  // ============================================================
  // values after reset
  localparam logic [PIN_W-1:0]  PIN_IDLE   = 15'h1b00;  // deselected, both strobes idle high
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic              MODE_RESET = 1'h0;      // separate-strobe style

  // ============================================================
  // write word handed to the display logic
  typedef struct packed {
    logic [HALVES-1:0] half_mask;  // bit 0 is half one
    logic              is_data;    // 1 display ram data, 0 instruction
    logic [DATA_W-1:0] value;
  } lhp_wr_word_s;

endpackage

`default_nettype wire

// ### tb/lhp_far_model.sv
// ============================================================
// Purpose: display logic stand-in behind the host bus port
// Assumes: one clock; words leave by valid and ready
// Notes:   a fetch is answered three cycles after its request
`default_nettype none

module lhp_far_model import lhp_pkg::*; (
  // bench control
  input  wire logic              clk,
  input  wire logic              stall,
  input  wire logic [DATA_W-1:0] fetch_value,
  // port side
  output logic                   wr_ready,
  input  wire logic              fetch_req,
  output logic                   fetch_valid,
  output logic      [DATA_W-1:0] fetch_data
);
  timeunit 1ns;
  timeprecision 1ns;

  int                wait_cnt = 0;
  logic              fv_reg   = 1'b0;
  logic [DATA_W-1:0] fd_reg   = 8'h3c;

  // words are taken unless the bench stalls the display logic
  assign wr_ready    = !stall;
  assign fetch_valid = fv_reg;
  assign fetch_data  = fd_reg;

  // fetch answer is late and the data lines carry junk meanwhile
  always @(posedge clk) begin
    if (fetch_req) wait_cnt <= 3;
    else if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
    fv_reg <= (wait_cnt == 1);
    fd_reg <= (wait_cnt == 1) ? fetch_value : ~fd_reg;
  end
endmodule

`default_nettype wire

// ### tb/tb_top.sv
// ============================================================
// Purpose: self-checking bench of the lcd host bus port
// Assumes: host pins held long against the four-edge pin latency
// Notes:   a queue model predicts words, latches and status
`default_nettype none

module tb_top import lhp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 0, reset = 1, a0 = 0, s1_n = 1, s2_n = 1, scan = 0;
  logic stb = 1, dir = 1, mpin = 0, stall = 0, drv = 0, em = 0;
  logic [7:0] hval = 8'h00, fval = 8'h00, q, fd, bus_in, bus_out;
  logic oe_n, wv, wrdy, fr, fh, fv, prp, bme, tick;
  logic [1:0] busy = 2'b00;
  logic [1:0][6:0] stat = '0;
  lhp_wr_word_s ww;
  lhp_wr_word_s exp_q[$];
  logic [7:0] lat[2] = '{8'h00, 8'h00};
  int error_cnt = 0, total_checks = 0, cyc = 0, ticks = 0, prps = 0;

  // released bus shows the inverse of the host's last byte
  assign bus_in = !oe_n ? bus_out : drv ? hval : ~hval;

  lhp_port u_dut (.clk(clk), .reset(reset), .data_or_command_select(a0),
    .half_one_select_n(s1_n), .half_two_select_n(s2_n), .scan_tick_input(scan),
    .strobe_pin(stb), .direction_pin(dir), .mode_reset_pin(mpin),
    .host_data_bus_in(bus_in), .host_data_bus_out(bus_out),
    .host_data_bus_oe_n(oe_n), .wr_valid(wv), .wr_word(ww), .wr_ready(wrdy),
    .fetch_req(fr), .fetch_half(fh), .fetch_valid(fv), .fetch_data(fd),
    .busy_flag(busy), .status_bits(stat), .port_reset_pulse(prp),
    .bus_mode_enable(bme), .scan_tick(tick));

  lhp_far_model u_far (.clk(clk), .stall(stall), .fetch_value(fval),
    .wr_ready(wrdy), .fetch_req(fr), .fetch_valid(fv), .fetch_data(fd));

  initial forever #10 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // word compare, pulse counts and the hang limit, on the falling edge once outputs settle
  always @(negedge clk) begin
    cyc++;
    if (tick) ticks++;
    if (prp) prps++;
    if (!reset && wv && wrdy) begin
      if (exp_q.size() == 0) chk("unexpected word", 1, 0);
      else chk("wr_word", ww, exp_q.pop_front());
    end
    if (cyc == 8000) begin
      error_cnt++;
      test_done();
    end
  end

  // one host access in the current bus style
  task automatic acc(input logic rd, input logic a, input logic [1:0] sel,
                     input logic [7:0] v);
    @(posedge clk) #1;
    a0 = a;
    s1_n = !sel[0];
    s2_n = !sel[1];
    hval = v;
    drv = !rd;
    if (em) dir = rd;
    repeat (4) @(posedge clk);
    #1;
    if (em) stb = 1;
    else if (rd) stb = 0;
    else dir = 0;
    repeat (10) @(posedge clk);
    #1;
    q = bus_out;
    chk("oe_n in access", oe_n, !(rd && sel != 0));
    if (em) stb = 0;
    else begin
      stb = 1;
      dir = 1;
    end
    if (!rd && sel != 0 && exp_q.size() < 2) exp_q.push_back({sel, a, v});
    repeat (14) @(posedge clk);
    #1;
    s1_n = 1;
    s2_n = 1;
    drv = 0;
    chk("oe_n idle", oe_n, 1);
    if (!stall) chk("words pending", exp_q.size(), 0);
  endtask

  // read status or display data of one half and compare
  task automatic rd(input logic a, input int h);
    logic [7:0] e;
    e = a ? lat[h] : {busy[h] | (exp_q.size() >= 2), stat[h]};
    fval = 8'($urandom);
    acc(1, a, h ? 2'b10 : 2'b01, 8'h00);
    chk("read byte", q, e);
    if (a) begin
      lat[h] = fval;
      chk("fetch_half", fh, h);
    end
  endtask

  // move the reset pin to pick a bus style
  task automatic setmode(input logic m);
    int n;
    @(posedge clk) #1;
    n = prps;
    mpin = m;
    stb = !m;
    dir = 1;
    em = m;
    repeat (12) @(posedge clk);
    #1;
    chk("reset pulses", prps - n, 1);
    chk("bus mode", bme, m);
    exp_q.delete();
    lat = '{8'h00, 8'h00};
  endtask

  // main sequence
  initial begin
    int n;
    void'($urandom(32'he2b9));
    repeat (6) @(posedge clk);
    #1 reset = 0;
    repeat (10) @(posedge clk);
    #1;
    chk("bus mode", bme, 0);
    for (int i = 0; i < 4; i++) acc(0, i[0], i[1:0], 8'($urandom));
    busy = 2'($urandom) | 2'h1;  // half one always busy so the flag is read high
    stat = 14'($urandom);
    rd(0, 0);
    rd(0, 1);
    rd(1, 0);
    rd(1, 0);
    rd(1, 1);
    $display("separate style test done");
    stall = 1;
    repeat (3) acc(0, 1, 2'b01, 8'($urandom));
    rd(0, 0);
    stall = 0;
    repeat (10) @(posedge clk);
    chk("buffer left", exp_q.size(), 0);
    $display("stall test done");
    setmode(1);
    for (int i = 1; i < 4; i++) acc(0, i[1], i[1:0], 8'($urandom));
    rd(0, 1);
    rd(1, 1);
    rd(1, 1);
    $display("enable style test done");
    setmode(0);
    acc(0, 1, 2'b10, 8'($urandom));
    rd(1, 1);
    $display("style return test done");
    n = ticks;
    repeat (3) begin
      @(posedge clk) #1 scan = 1;
      repeat (10) @(posedge clk);
      #1 scan = 0;
      repeat (10) @(posedge clk);
    end
    chk("scan ticks", ticks - n, 3);
    $display("scan test done");
    test_done();
  end
endmodule

`default_nettype wire
